//--- gauge_consts.svh
// register offsets, field positions, reset values and timing figures of the gauge controller
`ifndef GAUGE_CONSTS_SVH
`define GAUGE_CONSTS_SVH
`define OFS_MODE        12'h000
`define OFS_USER_I      12'h004
`define OFS_USER_P      12'h008
`define OFS_HOST_RATE   12'h00C
`define OFS_DESIGN_CAP  12'h010
`define OFS_DESIGN_NRG  12'h014
`define OFS_RESV_MAH    12'h018
`define OFS_RESV_MWH    12'h01C
`define OFS_THR_DSG     12'h020
`define OFS_THR_CHG     12'h024
`define OFS_QUIT_I      12'h028
`define OFS_RELAX_T     12'h02C
`define OFS_MEAS        12'h030
`define OFS_PREV_RUN    12'h034
`define OFS_STATUS      12'h038
`define OFS_LOAD_RATE   12'h03C
`define OFS_RESERVE     12'h040
`define OFS_QMAX0       12'h044
`define OFS_QMAX1       12'h048
`define OFS_LEARN0      12'h04C
`define OFS_LEARN1      12'h050
`define OFS_VOLT        12'h054
`define OFS_VSLOPE      12'h058
// control word fields
`define MODE_BIT        0
`define SEL_LSB         4
`define PROFILE_BIT     8
`define RESCAP_BIT      9
// status word and learn flag fields
`define ST_LOAD_MODEL   0
`define ST_RELAXED      1
`define ST_OCV_READY    2
`define ST_DSG_FLOW     3
`define ST_CHG_FLOW     4
`define ST_QMAX_EN      5
`define LEARN_BIT       0
`define LEARN_MASK      8'h01
// reset values
`define SEL_RESET       3'h1
`define QMAX_RESET      16'h03E8
`define DSG_RELAX_RST   16'h003C
`define CHG_RELAX_RST   16'h003C
`define QUIT_RELAX_RST  8'h01
`define VSLOPE_RST      16'h7FFF
// timing
`define CLK_HZ          125000000
`define OCV_WAIT_S      300
`define LPF_SHIFT       4
`define SLOPE_LIMIT_UV  16'h0004
`endif

//--- gauge_load_model_relax_ctrl.sv
// load model selection, reserve compensation and relaxation control with APB registers
//
// The implementer's own choices: the placing of the registers and the APB register port.
`include "gauge_consts.svh"

module gauge_load_model_relax_ctrl #(
  parameter int unsigned CLK_HZ     = `CLK_HZ,            // core clock rate
  parameter int unsigned OCV_WAIT_S = `OCV_WAIT_S         // relaxed time before readings
) (
  input  wire logic         clock,                // 125 MHz core clock
  input  wire logic         rst,                  // synchronous reset, active high
  input  wire logic         psel,                 // apb select
  input  wire logic         penable,              // apb access phase
  input  wire logic         pwrite,               // apb write
  input  wire logic [11:0]  paddr,                // apb byte address
  input  wire logic [31:0]  pwdata,               // apb write data
  output logic      [31:0]  prdata,               // apb read data
  output logic              pready,               // apb ready
  output logic              pslverr,              // apb error on unmapped address
  output logic              load_model_flag,      // constant power model active
  output logic              relaxed,              // relaxation mode
  output logic              ocv_sample,           // open circuit voltage reading window
  output logic              qmax_update_en,       // capacity update allowed
  output gauge_pkg::word_t  load_rate             // selected rate for compensation
);
  import gauge_pkg::*;

  // one second tick divider so relax times are in seconds
  localparam int unsigned SEC_CYC = CLK_HZ;
  logic [31:0] sec_cnt_q;
  logic        sec_tick_q;

  // software-owned configuration
  logic        mode_q;
  logic [2:0]  sel_q;
  logic        profile_q;
  logic        rescap_q;
  word_t       user_i_q, user_p_q, host_rate_q, design_cap_q, design_nrg_q;
  word_t       resv_mah_q, resv_mwh_q, thr_dsg_q, thr_chg_q, quit_i_q;
  word_t       dsg_relax_q, chg_relax_q;
  logic [7:0]  quit_relax_q;
  // measurement inputs written by the sampling firmware path
  word_t       mean_cell_current_q, volt_q, vslope_q, remaining_charge_q, remaining_energy_q;
  word_t       prev_i_q, prev_p_q, cyc_i_q, cyc_p_q;
  word_t       filt_q;
  word_t       qmax_q [2];
  logic [7:0]  learn_q [2];
  word_t       reserve_q;
  logic        dsg_flow_q, chg_flow_q;
  relax_state_t state_q;
  logic [15:0] below_cnt_q;
  logic [7:0]  above_cnt_q;
  logic [31:0] relax_sec_q;

  // magnitude of a signed reading
  function automatic word_t mag(input word_t v);
    mag = v[15] ? word_t'(-v) : v;
  endfunction

  // divide by five, low 16 bits
  function automatic word_t div5(input word_t v);
    div5 = word_t'(v / 16'h0005);
  endfunction

  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;

  always_ff @(posedge clock) begin
    if (rst || sec_cnt_q == SEC_CYC - 1) begin
      sec_cnt_q <= 32'h0;
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= (sec_cnt_q == SEC_CYC - 1);
    end
  end

  // configuration writes; defaults constant current and code 1
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q       <= 1'b0;
      sel_q        <= `SEL_RESET;
      profile_q    <= 1'b0;
      rescap_q     <= 1'b0;
      user_i_q     <= 16'h0000;
      user_p_q     <= 16'h0000;
      host_rate_q  <= 16'h0000;
      design_cap_q <= `QMAX_RESET;
      design_nrg_q <= 16'h0000;
      resv_mah_q   <= 16'h0000;
      resv_mwh_q   <= 16'h0000;
      thr_dsg_q    <= 16'h0000;
      thr_chg_q    <= 16'h0000;
      quit_i_q     <= 16'h0000;
      dsg_relax_q  <= `DSG_RELAX_RST;
      chg_relax_q  <= `CHG_RELAX_RST;
      quit_relax_q <= `QUIT_RELAX_RST;
      mean_cell_current_q <= 16'h0000;
      volt_q       <= 16'h0000;
      vslope_q     <= `VSLOPE_RST;  // steepest positive slope, no learning before a reading
      remaining_charge_q <= 16'h0000;
      remaining_energy_q <= 16'h0000;
      prev_i_q     <= 16'h0000;
      prev_p_q     <= 16'h0000;
    end else if (wr_en) begin
      case (paddr)
        `OFS_MODE: begin
          mode_q    <= pwdata[`MODE_BIT];
          sel_q     <= pwdata[`SEL_LSB+2:`SEL_LSB];
          profile_q <= pwdata[`PROFILE_BIT];
          rescap_q  <= pwdata[`RESCAP_BIT];
        end
        `OFS_USER_I:     user_i_q     <= pwdata[15:0];
        `OFS_USER_P:     user_p_q     <= pwdata[15:0];
        `OFS_HOST_RATE:  host_rate_q  <= pwdata[15:0];
        `OFS_DESIGN_CAP: design_cap_q <= pwdata[15:0];
        `OFS_DESIGN_NRG: design_nrg_q <= pwdata[15:0];
        `OFS_RESV_MAH:   resv_mah_q   <= pwdata[15:0];
        `OFS_RESV_MWH:   resv_mwh_q   <= pwdata[15:0];
        `OFS_THR_DSG:    thr_dsg_q    <= pwdata[15:0];
        `OFS_THR_CHG:    thr_chg_q    <= pwdata[15:0];
        `OFS_QUIT_I:     quit_i_q     <= pwdata[15:0];
        `OFS_RELAX_T: begin
          dsg_relax_q  <= {8'h00, pwdata[7:0]};
          chg_relax_q  <= {8'h00, pwdata[15:8]};
          quit_relax_q <= pwdata[23:16];
        end
        `OFS_MEAS: begin
          mean_cell_current_q <= pwdata[15:0];
          remaining_charge_q  <= pwdata[31:16];
        end
        `OFS_PREV_RUN: begin
          prev_i_q <= pwdata[15:0];
          prev_p_q <= pwdata[31:16];
        end
        `OFS_VOLT: begin
          volt_q             <= pwdata[15:0];
          remaining_energy_q <= pwdata[31:16];
        end
        `OFS_VSLOPE:     vslope_q     <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // real current flow detection against both thresholds
  always_ff @(posedge clock) begin
    if (rst) begin
      dsg_flow_q <= 1'b0;
      chg_flow_q <= 1'b0;
    end else begin
      dsg_flow_q <= mean_cell_current_q[15] && (mag(mean_cell_current_q) > thr_dsg_q);
      chg_flow_q <= !mean_cell_current_q[15] && (mean_cell_current_q > thr_chg_q);
    end
  end

  // 16 s low-pass, one step per second; signed shifts keep discharge currents negative
  always_ff @(posedge clock) begin
    if (rst) begin
      filt_q <= 16'h0000;
    end else if (sec_tick_q) begin
      filt_q <= word_t'($signed(filt_q) - ($signed(filt_q) >>> `LPF_SHIFT)
                        + ($signed(mean_cell_current_q) >>> `LPF_SHIFT));
    end
  end

  // present-cycle averages approximated by half-step averaging while discharging
  always_ff @(posedge clock) begin
    if (rst) begin
      cyc_i_q <= 16'h0000;
      cyc_p_q <= 16'h0000;
    end else if (sec_tick_q && dsg_flow_q) begin
      cyc_i_q <= word_t'((32'(cyc_i_q) + 32'(mag(mean_cell_current_q))) >> 1);
      cyc_p_q <= word_t'((32'(cyc_p_q) + ((32'(mag(mean_cell_current_q)) * 32'(volt_q)) >> 16)) >> 1);
    end
  end

  // rate behind load-compensated capacity
  always_ff @(posedge clock) begin
    if (rst) begin
      load_rate <= 16'h0000;
    end else if (!mode_q) begin
      case (sel_q)
        3'h0:    load_rate <= prev_i_q;
        3'h1:    load_rate <= cyc_i_q;
        3'h2:    load_rate <= mean_cell_current_q;
        3'h3:    load_rate <= filt_q;
        3'h4:    load_rate <= div5(design_cap_q);
        3'h5:    load_rate <= host_rate_q;
        3'h6:    load_rate <= user_i_q;
        default: load_rate <= cyc_i_q;
      endcase
    end else begin
      case (sel_q)
        3'h0:    load_rate <= prev_p_q;
        3'h1:    load_rate <= cyc_p_q;
        3'h2:    load_rate <= word_t'((32'(mag(mean_cell_current_q)) * 32'(volt_q)) >> 16);
        3'h3:    load_rate <= word_t'((32'(mag(filt_q)) * 32'(volt_q)) >> 16);
        3'h4:    load_rate <= div5(design_nrg_q);
        3'h5:    load_rate <= host_rate_q;
        3'h6:    load_rate <= user_p_q;
        default: load_rate <= cyc_p_q;
      endcase
    end
  end

  // reserve left after the reported value reaches zero, optionally halved as no-load comp
  always_ff @(posedge clock) begin
    if (rst) begin
      reserve_q <= 16'h0000;
    end else if (!mode_q) begin
      reserve_q <= (remaining_charge_q == 16'h0000) ?
                   (rescap_q ? (resv_mah_q >> 1) : resv_mah_q) : 16'h0000;
    end else begin
      reserve_q <= (remaining_energy_q == 16'h0000) ?
                   (rescap_q ? (resv_mwh_q >> 1) : resv_mwh_q) : 16'h0000;
    end
  end

  wire below_quit = mag(mean_cell_current_q) < quit_i_q;
  wire [15:0] relax_need = (dsg_relax_q < chg_relax_q) ? dsg_relax_q : chg_relax_q;

  // qualification timers, counted in seconds
  always_ff @(posedge clock) begin
    if (rst || !below_quit || state_q != ST_ACTIVE) begin
      below_cnt_q <= 16'h0000;
    end else if (sec_tick_q && below_cnt_q != 16'hFFFF) begin
      below_cnt_q <= below_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || below_quit || state_q == ST_ACTIVE) begin
      above_cnt_q <= 8'h00;
    end else if (sec_tick_q && above_cnt_q != 8'hFF) begin
      above_cnt_q <= above_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || state_q == ST_ACTIVE) begin
      relax_sec_q <= 32'h0;
    end else if (sec_tick_q && relax_sec_q != 32'hFFFFFFFF) begin
      relax_sec_q <= relax_sec_q + 32'h1;
    end
  end

  // relaxation state machine
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_ACTIVE;
    end else begin
      case (state_q)
        ST_ACTIVE: if (below_quit && below_cnt_q >= relax_need) state_q <= ST_RELAX;
        ST_RELAX: begin
          if (!below_quit && above_cnt_q >= quit_relax_q) state_q <= ST_ACTIVE;
          else if (relax_sec_q >= OCV_WAIT_S) state_q <= ST_OCV;
        end
        ST_OCV: if (!below_quit && above_cnt_q >= quit_relax_q) state_q <= ST_ACTIVE;
        default: state_q <= ST_ACTIVE;
      endcase
    end
  end

  wire slope_ok = mag(vslope_q) < `SLOPE_LIMIT_UV;

  // pin outputs follow state, load_model_flag follows mode_q, one flop each
  always_ff @(posedge clock) begin
    if (rst) begin
      relaxed         <= 1'b0;
      ocv_sample      <= 1'b0;
      qmax_update_en  <= 1'b0;
      load_model_flag <= 1'b0;
    end else begin
      relaxed         <= (state_q != ST_ACTIVE);
      ocv_sample      <= (state_q == ST_OCV);
      qmax_update_en  <= (state_q == ST_OCV) && slope_ok;
      load_model_flag <= mode_q;
    end
  end

  // per-profile capacity and learn flag; hardware learn beats a software write
  always_ff @(posedge clock) begin
    if (rst) begin
      qmax_q[0]  <= `QMAX_RESET;
      qmax_q[1]  <= `QMAX_RESET;
      learn_q[0] <= 8'h00;
      learn_q[1] <= 8'h00;
    end else begin
      if (wr_en && paddr == `OFS_QMAX0) qmax_q[0] <= pwdata[15:0];
      if (wr_en && paddr == `OFS_QMAX1) qmax_q[1] <= pwdata[15:0];
      if (wr_en && paddr == `OFS_LEARN0) learn_q[0] <= pwdata[7:0] & `LEARN_MASK;
      if (wr_en && paddr == `OFS_LEARN1) learn_q[1] <= pwdata[7:0] & `LEARN_MASK;
      if (qmax_update_en && sec_tick_q) begin
        qmax_q[profile_q] <= word_t'((32'(qmax_q[profile_q]) + 32'(remaining_charge_q)) >> 1);
        learn_q[profile_q][`LEARN_BIT] <= 1'b1;
      end
    end
  end

  // apb read mux; every access completes with no wait state
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0;
        case (paddr)
          `OFS_MODE:       prdata <= {22'h0, rescap_q, profile_q, 1'b0, sel_q, 3'h0, mode_q};
          `OFS_USER_I:     prdata <= {16'h0, user_i_q};
          `OFS_USER_P:     prdata <= {16'h0, user_p_q};
          `OFS_HOST_RATE:  prdata <= {16'h0, host_rate_q};
          `OFS_DESIGN_CAP: prdata <= {16'h0, design_cap_q};
          `OFS_DESIGN_NRG: prdata <= {16'h0, design_nrg_q};
          `OFS_RESV_MAH:   prdata <= {16'h0, resv_mah_q};
          `OFS_RESV_MWH:   prdata <= {16'h0, resv_mwh_q};
          `OFS_THR_DSG:    prdata <= {16'h0, thr_dsg_q};
          `OFS_THR_CHG:    prdata <= {16'h0, thr_chg_q};
          `OFS_QUIT_I:     prdata <= {16'h0, quit_i_q};
          `OFS_RELAX_T:    prdata <= {8'h0, quit_relax_q, chg_relax_q[7:0], dsg_relax_q[7:0]};
          `OFS_MEAS:       prdata <= {remaining_charge_q, mean_cell_current_q};
          `OFS_PREV_RUN:   prdata <= {prev_p_q, prev_i_q};
          `OFS_STATUS:     prdata <= {26'h0, qmax_update_en, chg_flow_q, dsg_flow_q,
                                      ocv_sample, relaxed, mode_q};
          `OFS_LOAD_RATE:  prdata <= {16'h0, load_rate};
          `OFS_RESERVE:    prdata <= {16'h0, reserve_q};
          `OFS_QMAX0:      prdata <= {16'h0, qmax_q[0]};
          `OFS_QMAX1:      prdata <= {16'h0, qmax_q[1]};
          `OFS_LEARN0:     prdata <= {24'h0, learn_q[0]};
          `OFS_LEARN1:     prdata <= {24'h0, learn_q[1]};
          `OFS_VOLT:       prdata <= {remaining_energy_q, volt_q};
          `OFS_VSLOPE:     prdata <= {16'h0, vslope_q};
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end

  // checks next to the logic
  a_flag_mirror: assert property (@(posedge clock) disable iff (rst)
    ##1 load_model_flag == $past(mode_q)) else $error("load model flag does not follow mode");
  a_rate_user_i: assert property (@(posedge clock) disable iff (rst)
    (!mode_q && sel_q == 3'h6 && $stable(user_i_q)) |=> load_rate == $past(user_i_q))
    else $error("user current rate not selected");
  a_rate_user_p: assert property (@(posedge clock) disable iff (rst)
    (mode_q && sel_q == 3'h6) |=> load_rate == $past(user_p_q)) else $error("user power rate not selected");
  a_relax_entry: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_ACTIVE && below_quit && below_cnt_q >= relax_need) |=> state_q == ST_RELAX)
    else $error("relax not entered after relax time");
  a_no_early_entry: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_ACTIVE && !below_quit) |=> state_q == ST_ACTIVE) else $error("relax entered with high current");
  a_ocv_after_relax: assert property (@(posedge clock) disable iff (rst)
    ocv_sample |-> relax_sec_q >= OCV_WAIT_S) else $error("ocv window too early");
  a_qmax_slope: assert property (@(posedge clock) disable iff (rst)
    qmax_update_en |-> $past(slope_ok) && $past(state_q == ST_OCV)) else $error("capacity update without slope");
  a_stay_relaxed: assert property (@(posedge clock) disable iff (rst)
    (state_q != ST_ACTIVE && below_quit) |=> state_q != ST_ACTIVE) else $error("relax left with low current");
  a_learn_set: assert property (@(posedge clock) disable iff (rst)
    (qmax_update_en && sec_tick_q && !profile_q) |=> learn_q[0][`LEARN_BIT]) else $error("learn bit not set");
endmodule // gauge_load_model_relax_ctrl

//--- gauge_pkg.sv
// types shared by the gauge load model and relax controller
package gauge_pkg;
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_RELAX  = 2'b01,
    ST_OCV    = 2'b10
  } relax_state_t;
  typedef logic [15:0] word_t;
endpackage

//--- tb_gauge_load_model_relax_ctrl.sv
// self-checking bench for the load model and relax controller over apb
module tb_gauge_load_model_relax_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import gauge_pkg::*;

  logic              clock   = 1'b0;
  logic              rst     = 1'b1;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [11:0]       paddr   = 12'h000;
  logic [31:0]       pwdata  = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              load_model_flag;
  logic              relaxed;
  logic              ocv_sample;
  logic              qmax_update_en;
  gauge_pkg::word_t  load_rate;
  int                errors   = 0;
  int                compares = 0;
  logic [31:0]       rv;
  logic              ev;

  // one simulated second is 100 cycles so relax timers finish quickly
  gauge_load_model_relax_ctrl #(.CLK_HZ(100), .OCV_WAIT_S(2)) DUT (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .load_model_flag(load_model_flag), .relaxed(relaxed),
    .ocv_sample(ocv_sample), .qmax_update_en(qmax_update_en), .load_rate(load_rate)
  );

  // 125 MHz core clock
  always #4 clock = ~clock;

  // verdict and end of run, shared with the watchdog
  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // apb transfer: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 1, 0);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000, rv, ev);
  endtask

  // select a model and code, let one second tick pass, compare the rate
  task automatic sel_chk(input logic m, input logic [2:0] c, input logic [15:0] exp);
    wr(12'h000, {25'h0, c, 3'h0, m});
    repeat (110) @(posedge clock);
    rd(12'h03C);
    chk("load rate reg", {16'h0, exp}, rv);
    chk("load rate port", {16'h0, exp}, {16'h0, load_rate});
    chk("load model flag", {31'h0, m}, {31'h0, load_model_flag});
  endtask

  // watchdog, well beyond the expected run of about 3700 cycles
  initial begin
    #160000;
    errors++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(12'h000); chk("control reset", 32'h0000_0010, rv);
    rd(12'h010); chk("design cap reset", 32'h0000_03E8, rv);
    rd(12'h044); chk("qmax0 reset", 32'h0000_03E8, rv);
    rd(12'h048); chk("qmax1 reset", 32'h0000_03E8, rv);
    rd(12'h04C); chk("learn0 reset", 32'h0000_0000, rv);
    rd(12'h02C); chk("relax times reset", 32'h0001_3C3C, rv);
    rd(12'hFFC); chk("unmapped err", 1, {31'h0, ev});
    chk("unmapped data", 0, rv);
    wr(12'h038, 32'hFFFF_FFFF);
    rd(12'h038); chk("status ro", 0, rv & 32'h7);
    $display("test reset and map done");
    // rate sources for codes 0, 1, 2, 4, 5 and 6
    wr(12'h004, 32'h0000_0011);
    wr(12'h008, 32'h0000_0033);
    wr(12'h00C, 32'h0000_0022);
    wr(12'h014, 32'h0000_01F4);
    wr(12'h030, 32'h07D0_0064);
    wr(12'h034, 32'h0070_0050);
    sel_chk(1'b0, 3'h0, 16'h0050);
    sel_chk(1'b0, 3'h2, 16'h0064);
    sel_chk(1'b0, 3'h4, 16'h00C8);
    sel_chk(1'b0, 3'h5, 16'h0022);
    sel_chk(1'b0, 3'h6, 16'h0011);
    sel_chk(1'b0, 3'h1, 16'h0000);
    sel_chk(1'b1, 3'h0, 16'h0070);
    sel_chk(1'b1, 3'h4, 16'h0064);
    sel_chk(1'b1, 3'h5, 16'h0022);
    sel_chk(1'b1, 3'h6, 16'h0033);
    sel_chk(1'b1, 3'h1, 16'h0000);
    rd(12'h038); chk("status model bit", 1, rv & 32'h1);
    $display("test load select done");
    // reserve once remaining charge and energy are empty
    wr(12'h030, 32'h0000_0064);
    wr(12'h054, 32'h0000_0E74);
    wr(12'h018, 32'h0000_0064);
    wr(12'h01C, 32'h0000_00C8);
    wr(12'h000, 32'h0000_0010);
    repeat (110) @(posedge clock);
    rd(12'h040); chk("reserve mah", 32'h0000_0064, rv);
    wr(12'h000, 32'h0000_0210);
    repeat (110) @(posedge clock);
    rd(12'h040); chk("reserve mah comp", 32'h0000_0032, rv);
    wr(12'h000, 32'h0000_0011);
    repeat (110) @(posedge clock);
    rd(12'h040); chk("reserve mwh", 32'h0000_00C8, rv);
    sel_chk(1'b1, 3'h2, 16'h0005);
    $display("test reserve done");
    // flow detection against both thresholds
    wr(12'h000, 32'h0000_0010);
    wr(12'h020, 32'h0000_0064);
    wr(12'h024, 32'h0000_0064);
    wr(12'h030, 32'h07D0_FF38);
    repeat (110) @(posedge clock);
    rd(12'h038); chk("flow dsg", 32'h8, rv & 32'h18);
    wr(12'h030, 32'h07D0_00C8);
    repeat (110) @(posedge clock);
    rd(12'h038); chk("flow chg", 32'h10, rv & 32'h18);
    $display("test thresholds done");
    // relax entry with a restart, then readings, learning and exit
    wr(12'h02C, 32'h0002_0302);
    wr(12'h028, 32'h0000_0032);
    wr(12'h030, 32'h07D0_0010);
    repeat (90) @(posedge clock);
    wr(12'h030, 32'h07D0_0064);
    repeat (110) @(posedge clock);
    wr(12'h030, 32'h07D0_0010);
    repeat (90) @(posedge clock);
    chk("relaxed early", 0, {31'h0, relaxed});
    chk("ocv early", 0, {31'h0, ocv_sample});
    repeat (220) @(posedge clock);
    chk("relaxed", 1, {31'h0, relaxed});
    repeat (330) @(posedge clock);
    chk("ocv window", 1, {31'h0, ocv_sample});
    chk("qmax steep", 0, {31'h0, qmax_update_en});
    wr(12'h058, 32'h0000_0003);
    repeat (110) @(posedge clock);
    chk("qmax flat", 1, {31'h0, qmax_update_en});
    repeat (220) @(posedge clock);
    rd(12'h04C); chk("learn0 set", 32'h0000_0001, rv);
    rd(12'h050); chk("learn1 clear", 32'h0000_0000, rv);
    rd(12'h048); chk("qmax1 kept", 32'h0000_03E8, rv);
    wr(12'h058, 32'h0000_0004);
    repeat (110) @(posedge clock);
    chk("qmax limit", 0, {31'h0, qmax_update_en});
    wr(12'h030, 32'h07D0_0064);
    repeat (90) @(posedge clock);
    chk("still relaxed", 1, {31'h0, relaxed});
    repeat (220) @(posedge clock);
    chk("left relax", 0, {31'h0, relaxed});
    wr(12'h050, 32'hFFFF_FFFF);
    rd(12'h050); chk("learn1 golden", 32'h0000_0001, rv);
    $display("test relax done");
    complete_run();
  end
endmodule // tb_gauge_load_model_relax_ctrl
